// [hw/pwt_pkg.sv]
// Functional notes
// - timeout sets read-only flag at bit 7
// - writing one to bit 6 clears flag
// - writing zero to ack changes nothing
// - ack bit is write-only, reads zero
// - bit 5 selects internal or external source
// - bit 4 enables interrupt requests
// - delay select zero disables the timer
// - internal delays 8 ms to 1.024 s
// - external delays divide by 256 to 32768
// - internal source is a free-running oscillator
// - unimplemented bits always read zero
package pwt_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] PWT_REG_OFF = 8'h00;
	localparam logic [7:0] PWT_REG_RESET = 8'h00;
	localparam int unsigned PWT_FLAG_BIT = 7;
	localparam int unsigned PWT_ACK_BIT = 6;
	localparam int unsigned PWT_CLKS_BIT = 5;
	localparam int unsigned PWT_IE_BIT = 4;
	localparam int unsigned PWT_DLY_LSB = 0;
	localparam int unsigned PWT_DLY_W = 3;

	// ----------------------------------------
	// bus responses
	// ----------------------------------------
	localparam logic [1:0] PWT_RESP_OKAY = 2'h0;
	localparam logic [1:0] PWT_RESP_DECERR = 2'h3;

	// ----------------------------------------
	// clock and delay tables
	// ----------------------------------------
	localparam int unsigned PWT_CLK_PERIOD_NS = 50;
	localparam int unsigned PWT_RTI_HZ = 1000;
	localparam logic [15:0] PWT_INT_MS_1 = 16'h0008;
	localparam logic [15:0] PWT_INT_MS_2 = 16'h0020;
	localparam logic [15:0] PWT_INT_MS_3 = 16'h0040;
	localparam logic [15:0] PWT_INT_MS_4 = 16'h0080;
	localparam logic [15:0] PWT_INT_MS_5 = 16'h0100;
	localparam logic [15:0] PWT_INT_MS_6 = 16'h0200;
	localparam logic [15:0] PWT_INT_MS_7 = 16'h0400;
	localparam logic [15:0] PWT_EXT_DIV_1 = 16'h0100;
	localparam logic [15:0] PWT_EXT_DIV_2 = 16'h0400;
	localparam logic [15:0] PWT_EXT_DIV_3 = 16'h0800;
	localparam logic [15:0] PWT_EXT_DIV_4 = 16'h1000;
	localparam logic [15:0] PWT_EXT_DIV_5 = 16'h2000;
	localparam logic [15:0] PWT_EXT_DIV_6 = 16'h4000;
	localparam logic [15:0] PWT_EXT_DIV_7 = 16'h8000;

	typedef struct packed {
		logic clk_sel;
		logic irq_en;
		logic [2:0] delay_sel;
	} pwt_ctrl_t;

	localparam pwt_ctrl_t PWT_CTRL_RESET = '{clk_sel: 1'b0, irq_en: 1'b0, delay_sel: 3'h0};

	// ticks of the chosen source per timeout
	function automatic logic [15:0] pwt_limit(input logic ext, input logic [2:0] sel);
		logic [15:0] ms;
		logic [15:0] dv;
		ms = 16'h0000;
		dv = 16'h0000;
		case (sel)
			3'h1: begin ms = PWT_INT_MS_1; dv = PWT_EXT_DIV_1; end
			3'h2: begin ms = PWT_INT_MS_2; dv = PWT_EXT_DIV_2; end
			3'h3: begin ms = PWT_INT_MS_3; dv = PWT_EXT_DIV_3; end
			3'h4: begin ms = PWT_INT_MS_4; dv = PWT_EXT_DIV_4; end
			3'h5: begin ms = PWT_INT_MS_5; dv = PWT_EXT_DIV_5; end
			3'h6: begin ms = PWT_INT_MS_6; dv = PWT_EXT_DIV_6; end
			3'h7: begin ms = PWT_INT_MS_7; dv = PWT_EXT_DIV_7; end
			default: begin ms = 16'h0000; dv = 16'h0000; end
		endcase
		if (ext) begin
			return dv;
		end
		return 16'((32'(ms) * PWT_RTI_HZ) / 1000);
	endfunction

endpackage

// [hw/pwt_sync.sv]
`timescale 1ns/1ps
module pwt_sync
	import pwt_pkg::*;
#(
	parameter int unsigned WIDTH = 2
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	// ----------------------------------------
	// two-stage synchroniser per bit
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_q;
			logic hold_q;
			always_ff @(posedge clock_i or negedge resetn_i) begin
				if (!resetn_i) begin
					meta_q <= 1'b0;
					hold_q <= 1'b0;
				end else begin
					meta_q <= async_i[i];
					hold_q <= meta_q;
				end
			end
			assign sync_o[i] = hold_q;
		end
	endgenerate

endmodule

// [hw/pwt_delay_cnt.sv]
`timescale 1ns/1ps
module pwt_delay_cnt
	import pwt_pkg::*;
#(
	parameter int unsigned CNT_SHIFT = 0
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// control
	input wire pwt_ctrl_t ctrl_i,
	input wire logic restart_i,
	input wire logic tick_i,
	// one-cycle timeout pulse
	output logic timeout_o
);

	logic [15:0] cnt_q;
	logic [15:0] lim;
	logic [15:0] last;

	// ----------------------------------------
	// terminal count
	// ----------------------------------------
	always_comb begin
		lim = pwt_limit(ctrl_i.clk_sel, ctrl_i.delay_sel) >> CNT_SHIFT;
		if (lim == 16'h0000) begin
			lim = 16'h0001;
		end
		last = lim - 16'h0001;
	end

	// ----------------------------------------
	// counter
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= 16'h0000;
			timeout_o <= 1'b0;
		end else begin
			timeout_o <= 1'b0;
			if (restart_i || ctrl_i.delay_sel == 3'h0) begin
				cnt_q <= 16'h0000;
			end else if (tick_i) begin
				if (cnt_q >= last) begin
					cnt_q <= 16'h0000;
					timeout_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
		end
	end

endmodule

// [hw/pwt_top.sv]
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module pwt_top
	import pwt_pkg::*;
#(
	parameter int unsigned ADDR_W = 8,
	parameter int unsigned CNT_SHIFT = 0
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// count sources, asynchronous to clock_i
	input wire logic osc_1khz_i,
	input wire logic ext_clk_i,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic [2:0] s_axi_awprot_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic [2:0] s_axi_arprot_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// interrupt request
	output logic irq_o
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [1:0] src_sync;
	logic src_lvl;
	logic src_prev_q;
	logic tick;
	logic timeout;

	logic [ADDR_W-1:0] awaddr_q;
	logic aw_full_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic w_full_q;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	logic wr_fire;
	logic wr_hit;
	logic ack_wr;
	logic rd_fire;
	logic rd_hit;

	pwt_ctrl_t ctrl_q;
	pwt_ctrl_t ctrl_d;
	logic restart_q;
	logic flag_q;
	logic flag_d;
	logic irq_q;
	logic [7:0] reg_view;

	// ----------------------------------------
	// count source selection
	// ----------------------------------------
	// the oscillator is its own free-running source, only sampled here
	// independent oscillator input
	pwt_sync #(
		.WIDTH(2)
	) u_sync (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.async_i({ext_clk_i, osc_1khz_i}),
		.sync_o(src_sync)
	);

	// external clock must stay below half of clock_i to be seen
	// source select
	assign src_lvl = ctrl_q.clk_sel ? src_sync[1] : src_sync[0];

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			src_prev_q <= 1'b0;
		end else begin
			src_prev_q <= src_lvl;
		end
	end

	assign tick = src_lvl & ~src_prev_q;

	// ----------------------------------------
	// delay counter
	// ----------------------------------------
	pwt_delay_cnt #(
		.CNT_SHIFT(CNT_SHIFT)
	) u_cnt (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.ctrl_i(ctrl_q),
		.restart_i(restart_q),
		.tick_i(tick),
		.timeout_o(timeout)
	);

	// ----------------------------------------
	// write address channel
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			awaddr_q <= '0;
		end else if (s_axi_awvalid_i && awready_q) begin
			awaddr_q <= s_axi_awaddr_i;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aw_full_q <= 1'b0;
		end else if (s_axi_awvalid_i && awready_q) begin
			aw_full_q <= 1'b1;
		end else if (wr_fire) begin
			aw_full_q <= 1'b0;
		end
	end

	// ready stays low until the response is taken, so one write is in flight
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			awready_q <= 1'b1;
		end else if (s_axi_awvalid_i && awready_q) begin
			awready_q <= 1'b0;
		end else if (bvalid_q && s_axi_bready_i) begin
			awready_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// write data channel
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid_i && wready_q) begin
			wdata_q <= s_axi_wdata_i;
			wstrb_q <= s_axi_wstrb_i;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			w_full_q <= 1'b0;
		end else if (s_axi_wvalid_i && wready_q) begin
			w_full_q <= 1'b1;
		end else if (wr_fire) begin
			w_full_q <= 1'b0;
		end
	end

	// address and data may come in either order; each half waits for the other
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wready_q <= 1'b1;
		end else if (s_axi_wvalid_i && wready_q) begin
			wready_q <= 1'b0;
		end else if (bvalid_q && s_axi_bready_i) begin
			wready_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// write decode and response
	// ----------------------------------------
	assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
	assign wr_hit = wr_fire && (awaddr_q[ADDR_W-1:2] == PWT_REG_OFF[ADDR_W-1:2]);
	// only a one in the ack bit acts
	assign ack_wr = wr_hit & wstrb_q[0] & wdata_q[PWT_ACK_BIT];

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bvalid_q <= 1'b0;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
		end else if (bvalid_q && s_axi_bready_i) begin
			bvalid_q <= 1'b0;
		end
	end

	// unmapped words answer with a decode error and change nothing
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bresp_q <= PWT_RESP_OKAY;
		end else if (wr_fire) begin
			bresp_q <= wr_hit ? PWT_RESP_OKAY : PWT_RESP_DECERR;
		end
	end

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_hit && wstrb_q[0]) begin
			ctrl_d.clk_sel = wdata_q[PWT_CLKS_BIT];
			ctrl_d.irq_en = wdata_q[PWT_IE_BIT];
			ctrl_d.delay_sel = wdata_q[PWT_DLY_LSB +: PWT_DLY_W];
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_q <= PWT_CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// a changed source or delay starts a fresh period; same-value writes keep phase
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			restart_q <= 1'b0;
		end else begin
			restart_q <= (ctrl_d.clk_sel != ctrl_q.clk_sel) ||
				(ctrl_d.delay_sel != ctrl_q.delay_sel);
		end
	end

	// ----------------------------------------
	// timeout flag and interrupt
	// ----------------------------------------
	always_comb begin
		flag_d = flag_q;
		if (ack_wr) begin
			flag_d = 1'b0;
		end
		// timeout sets flag, wins over ack
		if (timeout) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= flag_d & ctrl_d.irq_en;
		end
	end

	// ----------------------------------------
	// register view
	// ----------------------------------------
	always_comb begin
		reg_view = PWT_REG_RESET;
		reg_view[PWT_FLAG_BIT] = flag_q;
		reg_view[PWT_ACK_BIT] = 1'b0;
		reg_view[PWT_CLKS_BIT] = ctrl_q.clk_sel;
		reg_view[PWT_IE_BIT] = ctrl_q.irq_en;
		reg_view[PWT_DLY_LSB +: PWT_DLY_W] = ctrl_q.delay_sel;
	end

	// ----------------------------------------
	// read channels
	// ----------------------------------------
	assign rd_fire = s_axi_arvalid_i & arready_q;
	assign rd_hit = s_axi_araddr_i[ADDR_W-1:2] == PWT_REG_OFF[ADDR_W-1:2];

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			arready_q <= 1'b1;
		end else if (rd_fire) begin
			arready_q <= 1'b0;
		end else if (rvalid_q && s_axi_rready_i) begin
			arready_q <= 1'b1;
		end
	end

	// rvalid stands until rready is seen
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rvalid_q <= 1'b0;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

	// data is captured at the handshake and held until it is taken
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_q <= 32'h0000_0000;
			rresp_q <= PWT_RESP_OKAY;
		end else if (rd_fire) begin
			rdata_q <= rd_hit ? {24'h00_0000, reg_view} : 32'h0000_0000;
			rresp_q <= rd_hit ? PWT_RESP_OKAY : PWT_RESP_DECERR;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o = wready_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;
	assign irq_o = irq_q;

endmodule

// [tb/pwt_checker.sv]
`timescale 1ns/1ps
module pwt_checker
	import pwt_pkg::*;
#(
	parameter int unsigned ADDR_W = 8
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// write side
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_bvalid_o,
	// read side
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	// interrupt
	input wire logic irq_o
);
	logic wr_hs;
	logic wr_reg;
	logic en_q;
	logic [2:0] sel_q;
	assign wr_hs = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	assign wr_reg = wr_hs && s_axi_awaddr_i[ADDR_W-1:2] == '0 && s_axi_wstrb_i[0];
	// shadow fields; only valid while address and data are offered together
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			en_q <= 1'b0;
			sel_q <= 3'h0;
		end else if (wr_reg) begin
			en_q <= s_axi_wdata_i[PWT_IE_BIT];
			sel_q <= s_axi_wdata_i[2:0];
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!resetn_i);
	write_resp_a:
	assert property (wr_hs |-> ##2 s_axi_bvalid_o && !s_axi_awready_o)
		else $error("no write response");
	read_resp_a:
	assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
		else $error("no read response");
	ack_read_zero_a:
	assert property (s_axi_rvalid_o |-> !s_axi_rdata_o[PWT_ACK_BIT]) else $error("ack bit reads one");
	unused_zero_a:
	assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000 && !s_axi_rdata_o[3])
		else $error("unused bits read one");
	irq_off_a:
	assert property (wr_reg && !s_axi_wdata_i[PWT_IE_BIT] |-> ##2 !irq_o)
		else $error("irq not masked");
	irq_gate_a:
	assert property ($rose(irq_o) |-> en_q && sel_q != 3'h0) else $error("irq while off");
	irq_flag_a:
	assert property (s_axi_arvalid_i && s_axi_arready_o && irq_o |=> s_axi_rdata_o[PWT_FLAG_BIT])
		else $error("irq without flag");
	irq_hold_a:
	assert property ($fell(irq_o) |-> $past(wr_reg, 2)) else $error("irq dropped unasked");
	cover property ($rose(irq_o));
	cover property (wr_reg ##2 $fell(irq_o));
	cover property (s_axi_rvalid_o && s_axi_rdata_o[PWT_FLAG_BIT]);
endmodule
bind pwt_top pwt_checker #(.ADDR_W(ADDR_W)) i_chk (
	.clock_i, .resetn_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
	.s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .irq_o
);

// [tb/periodic_wakeup_timer_test.sv]
`timescale 1ns/1ps
module periodic_wakeup_timer_test;
	import pwt_pkg::*;
	// short counts keep the longest delay near two thousand cycles
	localparam int unsigned SH = 7;
	localparam logic [31:0] ONE = 32'h0000_0001;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic osc = 1'b0;
	logic ext = 1'b0;
	logic aw_v = 1'b0;
	logic w_v = 1'b0;
	logic b_r = 1'b0;
	logic ar_v = 1'b0;
	logic r_r = 1'b0;
	logic [7:0] aw_a = 8'h00;
	logic [7:0] ar_a = 8'h00;
	logic [31:0] w_d = 32'h0000_0000;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq;
	logic [1:0] b_rs, r_rs, rs;
	logic [31:0] r_d, d;
	int bad_count = 0;
	int num_checks = 0;
	initial forever #25 clk = ~clk;
	// free-running sources, phase unrelated to clk
	initial forever #500 osc = ~osc;
	initial begin
		#130;
		forever #200 ext = ~ext;
	end
	pwt_top #(.CNT_SHIFT(SH)) i_dut (
		.clock_i(clk), .resetn_i(rst_n), .osc_1khz_i(osc), .ext_clk_i(ext),
		.s_axi_awaddr_i(aw_a), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(aw_v),
		.s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hf),
		.s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_rs),
		.s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r), .s_axi_araddr_i(ar_a),
		.s_axi_arprot_i(3'h0), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy),
		.s_axi_rdata_o(r_d), .s_axi_rresp_o(r_rs), .s_axi_rvalid_o(r_v),
		.s_axi_rready_i(r_r), .irq_o(irq)
	);
	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		logic aw_done;
		logic w_done;
		logic b_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		b_done = 1'b0;
		@(posedge clk);
		aw_a <= a;
		w_d <= {24'h00_0000, x};
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		// each channel lets go at the edge where its own ready is seen
		while (!b_done) begin
			@(posedge clk);
			if (!aw_done && aw_rdy) begin
				aw_done = 1'b1;
				aw_v <= 1'b0;
			end
			if (!w_done && w_rdy) begin
				w_done = 1'b1;
				w_v <= 1'b0;
			end
			if (b_v) begin
				b_done = 1'b1;
				rs = b_rs;
				b_r <= 1'b0;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a);
		logic ar_done;
		logic r_done;
		ar_done = 1'b0;
		r_done = 1'b0;
		@(posedge clk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		while (!r_done) begin
			@(posedge clk);
			if (!ar_done && ar_rdy) begin
				ar_done = 1'b1;
				ar_v <= 1'b0;
			end
			if (r_v) begin
				r_done = 1'b1;
				d = r_d;
				rs = r_rs;
				r_r <= 1'b0;
			end
		end
	endtask
	task automatic rdchk(input logic [7:0] x);
		rd(8'h00);
		chk("rresp", 32'(rs), 32'(PWT_RESP_OKAY));
		chk("reg", d, {24'h00_0000, x});
	endtask
	task automatic wait_irq(output int e);
		e = 0;
		while (irq !== 1'b1 && e < 5000) begin
			@(negedge clk);
			e++;
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_fields();
		wr(8'h00, 8'hff);
		rdchk(8'h37);
		wr(8'h00, 8'h00);
		rdchk(8'h00);
	endtask
	task automatic t_off();
		for (int s = 0; s < 2; s++) begin
			wr(8'h00, s[0] ? 8'h70 : 8'h50);
			repeat (120) @(negedge clk);
			chk("irq", 32'(irq), 32'h0000_0000);
			rdchk(s[0] ? 8'h30 : 8'h10);
		end
	endtask
	task automatic t_period();
		int n;
		int p;
		int e;
		logic [7:0] c;
		for (int s = 0; s < 2; s++) begin
			for (int k = 1; k < 8; k++) begin
				n = ((k == 1) ? 256 : 256 << k) >> (s ? SH : SH + 5);
				n = (n == 0) ? 1 : n;
				p = s ? 8 : 20;
				c = {2'b00, s[0], 1'b1, 1'b0, k[2:0]};
				wr(8'h00, 8'h40);
				wr(8'h00, c);
				wait_irq(e);
				chk("delay", 32'(e >= (n - 1) * p && e <= n * p + 8), ONE);
				rdchk(c | 8'h80);
			end
		end
		wr(8'h00, 8'h40);
	endtask
	task automatic t_ack();
		int e;
		wr(8'h00, 8'h57);
		wait_irq(e);
		wr(8'h00, 8'h17);
		chk("irq", 32'(irq), ONE);
		rdchk(8'h97);
		wr(8'h00, 8'h57);
		chk("irq", 32'(irq), 32'h0000_0000);
		rdchk(8'h17);
	endtask
	task automatic t_noirq();
		wr(8'h00, 8'h41);
		repeat (60) @(negedge clk);
		chk("irq", 32'(irq), 32'h0000_0000);
		rdchk(8'h81);
		wr(8'h00, 8'h40);
	endtask
	task automatic t_unmap();
		wr(8'h04, 8'h17);
		chk("bresp", 32'(rs), 32'(PWT_RESP_DECERR));
		rd(8'h04);
		chk("rresp", 32'(rs), 32'(PWT_RESP_DECERR));
		chk("rdata", d, 32'h0000_0000);
		rdchk(8'h00);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#2_000_000;
		bad_count++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdchk(8'h00);
		t_fields();
		t_off();
		t_period();
		t_ack();
		t_noirq();
		t_unmap();
		summarize();
	end
endmodule
